// >>> rtl/eight_bit_cpu_instruction_decoder.sv
`include "decoder_defs.svh"
module eight_bit_cpu_instruction_decoder (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  busy,
  output logic                  done,
  output logic                  jumpTaken,
  output decoder_pkg::decode_t  decoded,
  output logic [3:0]            flags,
  output logic [7:0]            pairLoAddr,
  output logic [7:0]            pairHiAddr,
  output logic [7:0]            periphAddr,
  output logic [15:0]           effAddr
);
  import decoder_pkg::*;

  state_t     stReg;
  decode_t    decReg;
  decode_t    decNext;
  logic [7:0] opReg;
  logic [3:0] flagsReg;
  logic [3:0] flagsNext;
  logic [7:0] valReg;
  logic [7:0] bAccReg;
  logic [7:0] regNReg;
  logic [15:0] directReg;
  logic       fastReg;
  logic       takenReg;
  logic       takenNext;
  logic [5:0] totalReg;
  logic [5:0] totalNext;
  logic [5:0] elapsedReg;
  logic       doneReg;
  logic [31:0] prdataReg;
  logic       tick;
  logic       lastStep;
  logic       apbWr;
  logic       setup;
  logic       start;
  logic       mapped;
  logic       roHit;
  logic [7:0] result;

  // Opcode lookup on the write data, latched when a run starts
  opcode_table u_table (
    .opcode (pwdata[7:0]),
    .dec    (decNext)
  );

  // Machine cycle prescaler
  machine_cycle_timer u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .fast    (fastReg),
    .run     (stReg == ST_EXEC),
    .tick    (tick)
  );

  // Branch condition test against flags and operands
  function automatic logic cond_met(cond_t c, logic [3:0] f, logic [7:0] v,
                                    logic [7:0] m);
    logic r;
    r = 1'b0;
    unique case (c)
      C_ALWAYS: r = 1'b1;
      C_NEG:    r = f[`FLG_N];
      C_ZERO:   r = f[`FLG_Z];
      C_CARRY:  r = f[`FLG_C];
      C_POS:    r = !f[`FLG_N] && !f[`FLG_Z];
      C_POSZ:   r = !f[`FLG_N];
      C_NZ:     r = !f[`FLG_Z];
      C_NC:     r = !f[`FLG_C];
      C_BIT1:   r = |(v & m);
      C_BIT0:   r = |(~v & m);
      C_DECREMENT_JUMP_NONZERO:   r = (v != 8'h01);
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : cond_met

  // APB decode; the slave never inserts wait states
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign apbWr  = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_CONFIG);
  assign roHit  = (paddr == `OFS_STATUS) || (paddr == `OFS_ADDR) ||
                  (paddr == `OFS_EADDR);
  assign start  = ce && apbWr && (paddr == `OFS_OPCODE) && (stReg == ST_IDLE);
  assign pslverr = psel && penable && (!mapped || (pwrite && roHit) ||
                   (pwrite && paddr == `OFS_OPCODE && stReg != ST_IDLE));
  assign prdata = prdataReg;

  // Taken decision and run length fixed at the start
  always_comb begin
    takenNext = cond_met(decNext.cond, flagsReg, valReg, bAccReg);
    totalNext = decNext.cycles;
    if (takenNext && (decNext.cls == CLS_JUMP || decNext.cls == CLS_DECREMENT_JUMP_NONZERO)) begin
      totalNext = decNext.cycles + `JUMP_EXTRA;
    end
  end

  assign lastStep = tick && (elapsedReg == totalReg - 6'd1);

  // Result byte that drives the Z and N flags
  always_comb begin
    unique case (decReg.cond)
      C_BIT1:  result = valReg & bAccReg;
      C_BIT0:  result = ~valReg & bAccReg;
      C_DECREMENT_JUMP_NONZERO:  result = valReg - 8'h01;
      default: result = (opReg == 8'hC1) ? bAccReg : valReg;
    endcase
  end

  // Flag values written back when a run completes
  always_comb begin
    flagsNext = flagsReg;
    if (decReg.flagMask[`FLG_Z] && (decReg.cls == CLS_BITJUMP ||
        decReg.cls == CLS_DECREMENT_JUMP_NONZERO || opReg == 8'hC1 || opReg == 8'h80)) begin
      flagsNext[`FLG_Z] = (result == 8'h00);
      flagsNext[`FLG_N] = result[7];
      if (decReg.cls != CLS_DECREMENT_JUMP_NONZERO) begin
        flagsNext[`FLG_C] = 1'b0;
      end
    end
    unique case (opcode_sel(opReg))
      2'd1: flagsNext = valReg[3:0];
      2'd2: flagsNext[`FLG_C] = 1'b1;
      2'd3: flagsNext[`FLG_I] = !opReg[1];
      default: ;
    endcase
  end

  // Groups the control codes that set flags outright
  function automatic logic [1:0] opcode_sel(logic [7:0] op);
    logic [1:0] k;
    k = 2'd0;
    if (op == 8'h0B || op == 8'h08) k = 2'd1;
    if (op == 8'h07) k = 2'd2;
    if (op == 8'h05 || op == 8'h06) k = 2'd3;
    return k;
  endfunction : opcode_sel

  // Sequencer: idle, then one run of the decoded length
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stReg <= ST_IDLE;
    end else if (ce) begin
      unique case (stReg)
        ST_IDLE: if (start) stReg <= ST_EXEC;
        ST_EXEC: if (lastStep) stReg <= ST_IDLE;
        default: stReg <= ST_IDLE;
      endcase
    end
  end

  // Latched decode of the running instruction
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opReg    <= 8'h00;
      decReg   <= '{CLS_OTHER, 3'd1, 6'd1, 4'h0, C_NONE, 1'b0};
      takenReg <= 1'b0;
      totalReg <= 6'd1;
    end else if (start) begin
      opReg    <= pwdata[7:0];
      decReg   <= decNext;
      takenReg <= takenNext;
      totalReg <= totalNext;
    end
  end

  // Machine cycle count and completion pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsedReg <= 6'd0;
      doneReg    <= 1'b0;
    end else if (ce) begin
      doneReg <= lastStep && (stReg == ST_EXEC);
      if (start) begin
        elapsedReg <= 6'd0;
      end else if (tick) begin
        elapsedReg <= elapsedReg + 6'd1;
      end
    end
  end

  // Flags: completion wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsReg <= 4'h0;
    end else if (ce) begin
      if (stReg == ST_EXEC && lastStep) begin
        flagsReg <= flagsNext;
      end else if (apbWr && paddr == `OFS_FLAGS) begin
        flagsReg <= pwdata[3:0];
      end
    end
  end

  // Software-written operands and crystal select
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      valReg    <= 8'h00;
      bAccReg   <= 8'h00;
      regNReg   <= 8'h00;
      directReg <= 16'h0000;
      fastReg   <= 1'b0;
    end else if (ce && apbWr) begin
      if (paddr == `OFS_OPERAND) begin
        valReg  <= pwdata[7:0];
        bAccReg <= pwdata[15:8];
        regNReg <= pwdata[23:16];
      end
      if (paddr == `OFS_DIRECT) directReg <= pwdata[15:0];
      if (paddr == `OFS_CONFIG) fastReg <= pwdata[0];
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdataReg <= 32'h0000_0000;
    end else if (ce && setup) begin
      unique case (paddr)
        `OFS_OPCODE:  prdataReg <= {24'h0, opReg};
        `OFS_FLAGS:   prdataReg <= {28'h0, flagsReg};
        `OFS_OPERAND: prdataReg <= {8'h0, regNReg, bAccReg, valReg};
        `OFS_DIRECT:  prdataReg <= {16'h0, directReg};
        `OFS_STATUS:  prdataReg <= {2'b00, elapsedReg, opReg, 1'b0, totalReg,
                                    decReg.bytes, decReg.cls, takenReg, busy};
        `OFS_ADDR:    prdataReg <= {16'h0, pairHiAddr, pairLoAddr};
        `OFS_EADDR:   prdataReg <= {16'h0, effAddr};
        `OFS_CONFIG:  prdataReg <= {31'h0, fastReg};
        default:      prdataReg <= 32'h0000_0000;
      endcase
    end
  end

  // Operand addressing
  assign pairLoAddr = regNReg;
  assign pairHiAddr = regNReg - 8'h01;
  assign periphAddr = regNReg;
  assign effAddr    = directReg + (decReg.indexed ? {8'h00, bAccReg} : 16'h0000);
  assign busy       = (stReg == ST_EXEC);
  assign done       = doneReg;
  assign jumpTaken  = takenReg;
  assign decoded    = decReg;
  assign flags      = flagsReg;

  sequence s_run_of(logic [7:0] op);
    stReg == ST_EXEC ##0 opReg == op;
  endsequence

  sequence s_finish;
    stReg == ST_EXEC && lastStep;
  endsequence

  property p_dac_imm;
    @(posedge sys_clk) disable iff (!arst_n)
    s_run_of(8'h7E) |-> decReg.cls == CLS_DEC_ADD && decReg.cycles == 6'd11
                        && decReg.bytes == 3'd3 && decReg.flagMask == 4'h7;
  endproperty
  a_dac_imm: assert property (p_dac_imm) else $error("7E decode wrong");

  property p_dsb_imm;
    @(posedge sys_clk) disable iff (!arst_n)
    s_run_of(8'h7F) |-> decReg.cls == CLS_DEC_SUB && totalReg == 6'd11;
  endproperty
  a_dsb_imm: assert property (p_dsb_imm) else $error("7F decode wrong");

  property p_mul_ab;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_finish ##0 opReg == 8'h6C) |=> elapsedReg == 6'd44 && done;
  endproperty
  a_mul_ab: assert property (p_mul_ab) else $error("6C length wrong");

  property p_mul_rr;
    @(posedge sys_clk) disable iff (!arst_n)
    s_run_of(8'h4C) |-> decReg.bytes == 3'd3 && totalReg == 6'd49;
  endproperty
  a_mul_rr: assert property (p_mul_rr) else $error("4C decode wrong");

  property p_jump_extra;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_finish ##0 decReg.cls == CLS_JUMP) |=>
      elapsedReg == (takenReg ? 6'd7 : 6'd5);
  endproperty
  a_jump_extra: assert property (p_jump_extra) else $error("jump length");

  property p_decrement_jump_nonzero_rn;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_finish ##0 opReg == 8'hDA) |=> elapsedReg == (takenReg ? 6'd11 : 6'd9);
  endproperty
  a_decrement_jump_nonzero_rn: assert property (p_decrement_jump_nonzero_rn) else $error("DA length");

  property p_reti_flags;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_finish ##0 opReg == 8'h0B) |=> flagsReg == $past(valReg[3:0]);
  endproperty
  a_reti_flags: assert property (p_reti_flags) else $error("flags not restored");

  property p_test_b;
    @(posedge sys_clk) disable iff (!arst_n)
    (s_finish ##0 opReg == 8'hC1) |=>
      flagsReg[`FLG_Z] == ($past(bAccReg) == 8'h00) && !flagsReg[`FLG_C];
  endproperty
  a_test_b: assert property (p_test_b) else $error("test B flags");

  property p_pair;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && apbWr && paddr == `OFS_OPERAND) |=>
      pairLoAddr == $past(pwdata[23:16]) && pairHiAddr == $past(pwdata[23:16]) - 8'h01;
  endproperty
  a_pair: assert property (p_pair) else $error("pair high byte address");

  property p_index;
    @(posedge sys_clk) disable iff (!arst_n)
    s_run_of(8'hAE) |-> effAddr == directReg + {8'h00, bAccReg} && totalReg == 6'd16;
  endproperty
  a_index: assert property (p_index) else $error("indexed call");
endmodule : eight_bit_cpu_instruction_decoder

// >>> rtl/decoder_defs.svh
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH
// Register byte offsets on the APB
`define OFS_OPCODE  8'h00
`define OFS_FLAGS   8'h04
`define OFS_OPERAND 8'h08
`define OFS_DIRECT  8'h0C
`define OFS_STATUS  8'h10
`define OFS_ADDR    8'h14
`define OFS_EADDR   8'h18
`define OFS_CONFIG  8'h1C
// Flag bit positions
`define FLG_I 3
`define FLG_Z 2
`define FLG_N 1
`define FLG_C 0
// Machine cycle times in ns, system clock period in ns
`define CLK_NS      4
`define CYC_NS_SLOW 400
`define CYC_NS_FAST 250
// Extra machine cycles of a taken E0..E7 jump or decrement-jump; bit-test jumps take none
`define JUMP_EXTRA  6'd2
`endif

// >>> rtl/decoder_pkg.sv
package decoder_pkg;
  // Instruction groups
  typedef enum logic [3:0] {
    CLS_OTHER, CLS_DEC_ADD, CLS_DEC_SUB, CLS_MULT, CLS_INCDEC, CLS_LOGIC,
    CLS_PLOGIC, CLS_ROTATE, CLS_JUMP, CLS_BITJUMP, CLS_DECREMENT_JUMP_NONZERO, CLS_BRANCH,
    CLS_CALL, CLS_TRAP, CLS_RETURN, CLS_CONTROL
  } cls_t;
  // Branch conditions
  typedef enum logic [3:0] {
    C_NONE, C_ALWAYS, C_NEG, C_ZERO, C_CARRY, C_POS, C_POSZ, C_NZ, C_NC,
    C_BIT1, C_BIT0, C_DECREMENT_JUMP_NONZERO
  } cond_t;
  // Decoded instruction
  typedef struct packed {
    cls_t       cls;
    logic [2:0] bytes;
    logic [5:0] cycles;
    logic [3:0] flagMask;
    cond_t      cond;
    logic       indexed;
  } decode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;
endpackage : decoder_pkg

// >>> rtl/opcode_table.sv
module opcode_table (
  input  wire logic [7:0]         opcode,
  output decoder_pkg::decode_t    dec
);
  import decoder_pkg::*;

  // Cycles of the seven register-form logic ops, high nibble 1..7
  localparam logic [5:0] LOG_CYC [7] = '{6'd8, 6'd7, 6'd8, 6'd10, 6'd7, 6'd5, 6'd9};
  localparam logic [2:0] FRM_LEN [7] = '{3'd2, 3'd2, 3'd2, 3'd3, 3'd2, 3'd1, 3'd3};
  localparam logic [5:0] PER_CYC [3] = '{6'd10, 6'd9, 6'd11};
  localparam logic [2:0] PER_LEN [3] = '{3'd2, 3'd2, 3'd3};
  localparam logic [5:0] BR_CYC  [3] = '{6'd10, 6'd9, 6'd12};
  localparam logic [5:0] ONE_CYC [3] = '{6'd5, 6'd5, 6'd7};
  localparam logic [2:0] ONE_LEN [3] = '{3'd1, 3'd1, 3'd2};
  localparam logic [3:0] ZNC = 4'h7;
  localparam logic [3:0] IZNC = 4'hF;

  logic [3:0] hi;
  logic [3:0] lo;
  int         f;
  int         p;
  int         s;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  assign f  = int'(hi) - 1;
  assign p  = int'(hi) - 8;
  assign s  = int'(hi) - 11;

  // Every opcode reaches exactly one branch below
  always_comb begin
    dec = '{CLS_OTHER, 3'd1, 6'd1, 4'h0, C_NONE, 1'b0};
    if (hi >= 4'h1 && hi <= 4'h7) begin
      dec.bytes    = FRM_LEN[f];
      dec.flagMask = ZNC;
      unique case (lo)
        4'h3, 4'h4, 4'h5: begin
          dec.cls    = CLS_LOGIC;
          dec.cycles = LOG_CYC[f];
        end
        4'hE: begin
          dec.cls    = CLS_DEC_ADD;
          dec.cycles = LOG_CYC[f] + 6'd2;
        end
        4'hF: begin
          dec.cls    = CLS_DEC_SUB;
          dec.cycles = LOG_CYC[f] + 6'd2;
        end
        4'hC: begin
          dec.cls    = CLS_MULT;
          dec.cycles = LOG_CYC[f] + 6'd39;
        end
        4'h6, 4'h7: begin
          dec.cls    = CLS_BITJUMP;
          dec.bytes  = FRM_LEN[f] + 3'd1;
          dec.cycles = LOG_CYC[f] + 6'd2;
          dec.cond   = lo[0] ? C_BIT0 : C_BIT1;
        end
        default: dec.flagMask = 4'h0;
      endcase
    end else if (opcode == 8'h80) begin
      // Test A and clear carry share this code
      dec = '{CLS_CONTROL, 3'd1, 6'd6, ZNC, C_NONE, 1'b0};
    end else if (hi >= 4'h8 && hi <= 4'hA) begin
      dec.indexed = (hi == 4'hA) && (lo == 4'hC || lo == 4'hE);
      unique case (lo)
        4'h3, 4'h4, 4'h5:
          dec = '{CLS_PLOGIC, PER_LEN[p], PER_CYC[p], ZNC, C_NONE, 1'b0};
        4'h6, 4'h7:
          dec = '{CLS_BITJUMP, PER_LEN[p] + 3'd1, PER_CYC[p] + 6'd1, ZNC,
                  lo[0] ? C_BIT0 : C_BIT1, 1'b0};
        4'hC: begin
          dec.cls    = CLS_BRANCH;
          dec.bytes  = (hi == 4'h9) ? 3'd2 : 3'd3;
          dec.cycles = BR_CYC[p];
        end
        4'hE: begin
          dec.cls    = CLS_CALL;
          dec.bytes  = (hi == 4'h9) ? 3'd2 : 3'd3;
          dec.cycles = BR_CYC[p] + 6'd4;
        end
        default: dec.cycles = 6'd1;
      endcase
    end else if (opcode == 8'hC1) begin
      dec = '{CLS_CONTROL, 3'd1, 6'd5, ZNC, C_NONE, 1'b0};
    end else if (hi >= 4'hB && hi <= 4'hD) begin
      dec.bytes    = ONE_LEN[s];
      dec.cycles   = ONE_CYC[s];
      dec.flagMask = ZNC;
      unique case (lo)
        4'h2, 4'h3: dec.cls = CLS_INCDEC;
        4'h4, 4'h5: dec.cls = CLS_LOGIC;
        4'hC, 4'hD, 4'hE, 4'hF: dec.cls = CLS_ROTATE;
        4'hB: begin
          dec.cls    = CLS_INCDEC;
          dec.cycles = ONE_CYC[s] + 6'd4;
        end
        4'hA: begin
          dec.cls      = CLS_DECREMENT_JUMP_NONZERO;
          dec.bytes    = ONE_LEN[s] + 3'd1;
          dec.cycles   = ONE_CYC[s] + 6'd2;
          dec.cond     = C_DECREMENT_JUMP_NONZERO;
          dec.flagMask = (hi == 4'hB) ? ZNC : 4'h0;
        end
        default: dec = '{CLS_OTHER, 3'd1, 6'd1, 4'h0, C_NONE, 1'b0};
      endcase
    end else if (hi == 4'hE && !lo[3]) begin
      // E0 always jumps; E1..E7 test the flags, E4 testing N and Z together
      dec = '{CLS_JUMP, 3'd2, 6'd5, 4'h0, cond_t'(lo + 4'd1), 1'b0};
    end else if (hi >= 4'hE) begin
      dec = '{CLS_TRAP, 3'd1, 6'd14, 4'h0, C_NONE, 1'b0};
    end else begin
      unique case (opcode)
        8'h00: dec.cycles = 6'd4;
        8'h01: dec = '{CLS_CONTROL, 3'd1, 6'd6, 4'h0, C_NONE, 1'b0};
        8'h05, 8'h06, 8'h07: dec = '{CLS_CONTROL, 3'd1, 6'd5, IZNC, C_NONE, 1'b0};
        8'h08, 8'h0E: dec = '{CLS_CONTROL, 3'd1, 6'd6, IZNC, C_NONE, 1'b0};
        8'h09: dec = '{CLS_CONTROL, 3'd1, 6'd6, 4'h0, C_NONE, 1'b0};
        8'h0D: dec = '{CLS_CONTROL, 3'd1, 6'd5, 4'h0, C_NONE, 1'b0};
        8'h0A: dec = '{CLS_RETURN, 3'd1, 6'd7, 4'h0, C_NONE, 1'b0};
        8'h0B: dec = '{CLS_RETURN, 3'd1, 6'd9, IZNC, C_NONE, 1'b0};
        default: dec.cycles = 6'd1;
      endcase
    end
  end
endmodule : opcode_table

// >>> rtl/machine_cycle_timer.sv
`include "decoder_defs.svh"
module machine_cycle_timer #(
  parameter int SLOW_CLKS = (`CYC_NS_SLOW + `CLK_NS - 1) / `CLK_NS,
  parameter int FAST_CLKS = (`CYC_NS_FAST + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic fast,
  input  wire logic run,
  output logic      tick
);
  // Refuse machine cycle lengths that the 7-bit prescaler cannot count
  if (SLOW_CLKS < 1 || SLOW_CLKS > 127 || FAST_CLKS < 1 || FAST_CLKS > 127) begin : g_bad_len
    $error("machine cycle length out of range");
  end

  logic [6:0] cntReg;
  logic [6:0] lim;

  // Clocks per machine cycle for the selected crystal
  assign lim  = fast ? 7'(FAST_CLKS - 1) : 7'(SLOW_CLKS - 1);
  assign tick = ce && run && (cntReg == lim);

  // Prescaler, restarts whenever the sequencer stops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntReg <= 7'h00;
    end else if (ce) begin
      if (!run || tick) begin
        cntReg <= 7'h00;
      end else begin
        cntReg <= cntReg + 7'h01;
      end
    end
  end
endmodule : machine_cycle_timer

// >>> verification/register_file_model.sv
module register_file_model (
  input  wire logic [7:0] regNum,
  output logic      [7:0] regValue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cells [256];
  // Every location starts out holding its own number, so a value is picked by address
  initial begin
    for (int i = 0; i < 256; i++) begin
      cells[i] = i[7:0];
    end
  end
  // Asynchronous read port
  assign regValue = cells[regNum];
endmodule : register_file_model

// >>> verification/eight_bit_cpu_instruction_decoder_bench.sv
`include "decoder_defs.svh"
module eight_bit_cpu_instruction_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import decoder_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] flg;
    logic [7:0] n;
    logic [7:0] b;
    logic [2:0] by;
    logic [5:0] cy;
    logic       tk;
    logic [3:0] mask;
    logic [3:0] res;
  } row_t;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, busy, done, jumpTaken, e;
  logic        ce;
  logic [7:0]  paddr, pairLoAddr, pairHiAddr, periphAddr, regNum, regValue;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] effAddr;
  logic [3:0]  flags;
  decode_t     decoded;
  int          checks, mismatches, cycles, cnt;
  // Opcode, flags before, register number, B, then bytes, cycles, taken, flag mask, flags after
  row_t rows [29] = '{
    '{8'h7E, 4'h0, 8'h10, 8'h00, 3'h3, 6'h0B, 1'b0, 4'h7, 4'h0},
    '{8'h7F, 4'h0, 8'h10, 8'h00, 3'h3, 6'h0B, 1'b0, 4'h7, 4'h0},
    '{8'h6C, 4'h0, 8'h10, 8'h00, 3'h1, 6'h2C, 1'b0, 4'h7, 4'h0},
    '{8'h4C, 4'h0, 8'h10, 8'h00, 3'h3, 6'h31, 1'b0, 4'h7, 4'h0},
    '{8'hDB, 4'h0, 8'h10, 8'h00, 3'h2, 6'h0B, 1'b0, 4'h7, 4'h0},
    '{8'h73, 4'h0, 8'h10, 8'h00, 3'h3, 6'h09, 1'b0, 4'h7, 4'h0},
    '{8'h74, 4'h0, 8'h10, 8'h00, 3'h3, 6'h09, 1'b0, 4'h7, 4'h0},
    '{8'h45, 4'h0, 8'h10, 8'h00, 3'h3, 6'h0A, 1'b0, 4'h7, 4'h0},
    '{8'hA3, 4'h0, 8'h10, 8'h00, 3'h3, 6'h0B, 1'b0, 4'h7, 4'h0},
    '{8'hDF, 4'h0, 8'h10, 8'h00, 3'h2, 6'h07, 1'b0, 4'h7, 4'h0},
    '{8'hAE, 4'h0, 8'h10, 8'h00, 3'h3, 6'h10, 1'b0, 4'h0, 4'h0},
    '{8'h0D, 4'h5, 8'h10, 8'h00, 3'h1, 6'h05, 1'b0, 4'h0, 4'h5},
    '{8'h0E, 4'h0, 8'h10, 8'h00, 3'h1, 6'h06, 1'b0, 4'hF, 4'h0},
    '{8'hC1, 4'h8, 8'h10, 8'h80, 3'h1, 6'h05, 1'b0, 4'h7, 4'hA},
    '{8'h0B, 4'h0, 8'h0A, 8'h00, 3'h1, 6'h09, 1'b0, 4'hF, 4'hA},
    '{8'h66, 4'h0, 8'h81, 8'h80, 3'h2, 6'h07, 1'b1, 4'h7, 4'h2},
    '{8'hA7, 4'h0, 8'hFF, 8'h01, 3'h4, 6'h0C, 1'b0, 4'h7, 4'h4},
    '{8'hDA, 4'h0, 8'h05, 8'h00, 3'h3, 6'h0B, 1'b1, 4'h0, 4'h0},
    '{8'hDA, 4'h0, 8'h01, 8'h00, 3'h3, 6'h09, 1'b0, 4'h0, 4'h0},
    '{8'hE1, 4'h2, 8'h10, 8'h00, 3'h2, 6'h07, 1'b1, 4'h0, 4'h2},
    '{8'hE2, 4'h0, 8'h10, 8'h00, 3'h2, 6'h05, 1'b0, 4'h0, 4'h0},
    '{8'hE3, 4'h1, 8'h10, 8'h00, 3'h2, 6'h07, 1'b1, 4'h0, 4'h1},
    '{8'hE4, 4'h0, 8'h10, 8'h00, 3'h2, 6'h07, 1'b1, 4'h0, 4'h0},
    '{8'hE5, 4'h2, 8'h10, 8'h00, 3'h2, 6'h05, 1'b0, 4'h0, 4'h2},
    '{8'hE6, 4'h4, 8'h10, 8'h00, 3'h2, 6'h05, 1'b0, 4'h0, 4'h4},
    '{8'h80, 4'h1, 8'h80, 8'h00, 3'h1, 6'h06, 1'b0, 4'h7, 4'h2},
    '{8'h8E, 4'h0, 8'h10, 8'h00, 3'h3, 6'h0E, 1'b0, 4'h0, 4'h0},
    '{8'hFF, 4'h0, 8'h10, 8'h00, 3'h1, 6'h0E, 1'b0, 4'h0, 4'h0},
    '{8'h05, 4'h0, 8'h10, 8'h00, 3'h1, 6'h05, 1'b0, 4'hF, 4'h8}};

  eight_bit_cpu_instruction_decoder dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done),
    .jumpTaken(jumpTaken), .decoded(decoded), .flags(flags), .pairLoAddr(pairLoAddr),
    .pairHiAddr(pairHiAddr), .periphAddr(periphAddr), .effAddr(effAddr));
  register_file_model regFile (.regNum(regNum), .regValue(regValue));

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task waitDone;
    cnt = 0;
    while (done !== 1'b1 && cnt < 4000) begin
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt >= 4000) chk("done", 32'h1, 32'h0);
  endtask : waitDone
  task runOp(input logic [7:0] op);
    apb(1'b1, `OFS_OPCODE, {24'h0, op});
    waitDone();
  endtask : runOp
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; regNum = 8'h00;
    ce = 1'b1;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk("flagsReset", 32'h0, flags);
    chk("busyReset", 32'h0, busy);
    apb(1'b1, `OFS_CONFIG, 32'h1);
    foreach (rows[i]) begin
      regNum <= rows[i].n;
      apb(1'b1, `OFS_FLAGS, {28'h0, rows[i].flg});
      apb(1'b1, `OFS_OPERAND, {8'h00, rows[i].n, rows[i].b, regValue});
      runOp(rows[i].op);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("bytes", rows[i].by, q[8:6]);
      chk("cycles", rows[i].cy, q[14:9]);
      chk("taken", rows[i].tk, q[1]);
      chk("jumpTaken", rows[i].tk, jumpTaken);
      chk("elapsed", rows[i].cy, q[29:24]);
      chk("flags", rows[i].res, flags);
      chk("mask", rows[i].mask, decoded.flagMask);
      chk("pairHi", rows[i].n - 8'h01, pairHiAddr);
      chk("pairLo", rows[i].n, pairLoAddr);
      chk("periph", rows[i].n, periphAddr);
    end
    // Indexed address wraps at 16 bits; register pair below location 0 wraps
    apb(1'b1, `OFS_OPERAND, 32'h0000_2000);
    apb(1'b1, `OFS_DIRECT, 32'h0000_FFF0);
    runOp(8'hAE);
    chk("effAddr", 32'h0010, effAddr);
    chk("pairHiWrap", 32'hFF, pairHiAddr);
    // Opcode write during a run is refused and the run keeps its length
    apb(1'b1, `OFS_OPCODE, 32'h6C);
    apb(1'b1, `OFS_OPCODE, 32'h00);
    chk("busyRefused", 32'h1, e);
    waitDone();
    chk("runKept", 32'h2C, decoded.cycles);
    // Unmapped read answers with an error and zero data
    apb(1'b0, 8'h20, 32'h0);
    chk("unmappedErr", 32'h1, e);
    chk("unmappedData", 32'h0, q);
    // Slow crystal: five machine cycles of 100 clocks each
    apb(1'b1, `OFS_CONFIG, 32'h0);
    runOp(8'h0D);
    chk("cycleLength", 32'h1, (cnt >= 499 && cnt <= 504));
    // Clock enable low freezes a run and refuses register writes
    apb(1'b1, `OFS_FLAGS, 32'h3);
    apb(1'b1, `OFS_OPCODE, 32'h00);
    ce <= 1'b0;
    apb(1'b1, `OFS_FLAGS, 32'hF);
    repeat (600) @(posedge sys_clk);
    chk("ceBusy", 32'h1, busy);
    chk("ceFlags", 32'h3, flags);
    ce <= 1'b1;
    waitDone();
    chk("ceIdle", 32'h0, busy);
    // Reset in the middle of a run returns to idle with cleared flags
    apb(1'b1, `OFS_OPCODE, 32'h6C);
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    chk("rstBusy", 32'h0, busy);
    chk("rstFlags", 32'h0, flags);
    arst_n <= 1'b1;
    runOp(8'h00);
    chk("rstCycles", 32'h4, decoded.cycles);
    tally_and_finish();
  end
endmodule : eight_bit_cpu_instruction_decoder_bench
